// file: shared/wdtu_pkg.sv
// Constants, types and register map of the watchdog with timed unlock
package wdtu_pkg;

    localparam int WDTU_DATA_W = 8;
    localparam int WDTU_ADDR_W = 3;

    // Register offsets
    localparam logic [2:0] WDTU_OFS_CTRL = 3'h0;
    localparam logic [2:0] WDTU_OFS_FLAG = 3'h1;
    localparam logic [2:0] WDTU_OFS_STS = 3'h2;
    localparam logic [2:0] WDTU_OFS_MASK = 3'h3;

    // Control field positions
    localparam int WDTU_CE_BIT = 4;
    localparam int WDTU_EN_BIT = 3;
    localparam int WDTU_PS_LSB = 0;
    localparam int WDTU_PS_W = 3;
    localparam int WDTU_FLAG_BIT = 0;

    // Interrupt event bits
    localparam int WDTU_EV_TMO = 0;
    localparam int WDTU_EV_REF = 1;
    localparam int WDTU_EV_N = 2;

    // Reset values
    localparam logic [2:0] WDTU_PS_RST = 3'h0;
    localparam logic [1:0] WDTU_EV_RST = 2'h0;
    localparam logic [7:0] WDTU_DATA_ZERO = 8'h00;

    // Timing counts
    localparam int WDTU_WIN_CYC = 4;
    localparam logic [1:0] WDTU_WIN_LOAD = 2'(WDTU_WIN_CYC - 1);
    localparam int WDTU_BASE_TICKS = 16384;
    localparam int WDTU_CNT_W = 22;

    // Unlock window state
    typedef enum logic [0:0] {
        WDTU_LOCKED = 1'b0,
        WDTU_OPEN = 1'b1
    } wdtu_lock_e;

    // Control register layout
    typedef struct packed {
        logic [2:0] rsvd;
        logic ce;
        logic en;
        logic [2:0] ps;
    } wdtu_ctrl_s;

endpackage : wdtu_pkg

// file: verilog/wdtu_sync.sv
// Two-flop synchroniser for pin inputs, one stage pair per bit
`timescale 1ns/10ps
module wdtu_sync
    import wdtu_pkg::*;
#(
    parameter int W = 2 // Number of bits
) (
    input wire logic clk, // System clock
    input wire logic rst_n, // Synchronous reset, active low
    input wire logic clk_en, // Freezes state when low
    input wire logic [W-1:0] async_in, // Pin levels
    output logic [W-1:0] sync_out // Synchronised levels
);

    genvar gi;

    // One synchroniser pair per bit
    generate
        for (gi = 0; gi < W; gi++) begin : g_bit
            logic meta_q;
            logic sync_q;
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    meta_q <= 1'b0;
                    sync_q <= 1'b0;
                end else if (clk_en) begin
                    meta_q <= async_in[gi];
                    sync_q <= meta_q;
                end
            end
            assign sync_out[gi] = sync_q;
        end
    endgenerate

endmodule : wdtu_sync

// file: verilog/wdtu_top.sv
// Watchdog timer with timed unlock, reset pulse and event interrupt
`timescale 1ns/10ps
module wdtu_top
    import wdtu_pkg::*;
#(
    parameter int BASE_TICKS = WDTU_BASE_TICKS // Shortest timeout
) (
    input wire logic clk, // System clock, 200 MHz
    input wire logic rst_n, // Chip reset, sync, active low
    input wire logic por_n, // Power-on reset, sync, active low
    input wire logic clk_en, // Freezes all state when low
    input wire logic osc_in, // 1 MHz watchdog oscillator pin
    input wire logic fuse_in, // Always-on fuse, high=programmed
    input wire logic restart_req, // Restart instruction pulse
    input wire logic [WDTU_ADDR_W-1:0] addr, // Register address
    input wire logic [WDTU_DATA_W-1:0] wdata, // Write data
    input wire logic wr, // Write strobe
    input wire logic rd, // Read strobe
    output logic [WDTU_DATA_W-1:0] rdata, // Read data, next cycle
    output logic irq, // Level interrupt
    output logic wdt_rst // One-cycle watchdog reset pulse
);

    // Registers
    wdtu_lock_e lock_q;
    wdtu_lock_e lock_d;
    logic [1:0] win_q;
    logic [1:0] win_d;
    logic en_q;
    logic en_d;
    logic [2:0] ps_q;
    logic [2:0] ps_d;
    logic [WDTU_CNT_W-1:0] cnt_q;
    logic [WDTU_CNT_W-1:0] cnt_d;
    logic osc_prev_q;
    logic flag_q;
    logic flag_d;
    logic [WDTU_EV_N-1:0] sts_q;
    logic [WDTU_EV_N-1:0] sts_d;
    logic [WDTU_EV_N-1:0] mask_q;
    logic [WDTU_EV_N-1:0] mask_d;
    logic [WDTU_DATA_W-1:0] rdata_q;
    logic irq_q;
    logic wdt_rst_q;

    // Synchronised pins
    logic [1:0] pins_s;
    wire osc_s = pins_s[0];
    wire fuse_s = pins_s[1];

    // Oscillator and fuse cross into the system clock domain
    wdtu_sync #(
        .W(2)
    ) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .async_in({fuse_in, osc_in}),
        .sync_out(pins_s)
    );

    // Address decode
    wire sel_ctrl = addr == WDTU_OFS_CTRL;
    wire sel_flag = addr == WDTU_OFS_FLAG;
    wire sel_sts = addr == WDTU_OFS_STS;
    wire sel_mask = addr == WDTU_OFS_MASK;
    wire wr_ctrl = wr && sel_ctrl;
    wire wr_flag = wr && sel_flag;
    wire wr_sts = wr && sel_sts;
    wire wr_mask = wr && sel_mask;

    // Written control fields
    wire wd_ce = wdata[WDTU_CE_BIT];
    wire wd_en = wdata[WDTU_EN_BIT];
    wire [2:0] wd_ps = wdata[WDTU_PS_LSB +: WDTU_PS_W];

    // Unlock window
    wire win_open = lock_q == WDTU_OPEN;
    // Opening write sets change-enable and enable together
    wire unlock = wr_ctrl && wd_ce && wd_en;
    // Second write inside the window with change-enable clear
    wire apply = wr_ctrl && win_open && !wd_ce;

    // Effective enable; programmed fuse forces it on
    wire en_eff = en_q || fuse_s;

    // Locked write that tries to disable or retime
    wire try_dis = !wd_en && en_eff;
    wire try_ps = wd_ps != ps_q;
    wire refuse = wr_ctrl && !apply && !unlock
        && (try_dis || try_ps);

    // Unlock window state machine, four cycles open
    always_comb begin
        lock_d = lock_q;
        win_d = win_q;
        case (lock_q)
            WDTU_LOCKED: begin
                if (unlock) begin
                    lock_d = WDTU_OPEN;
                    win_d = WDTU_WIN_LOAD;
                end
            end
            WDTU_OPEN: begin
                if (unlock) begin
                    win_d = WDTU_WIN_LOAD;
                end else if (win_q == 2'h0) begin
                    lock_d = WDTU_LOCKED;
                end else begin
                    win_d = win_q - 2'h1;
                end
            end
            default: begin
                lock_d = WDTU_LOCKED;
                win_d = 2'h0;
            end
        endcase
    end

    // Enable: set freely, cleared only by a window write
    assign en_d = apply ? wd_en
        : (wr_ctrl && wd_en) ? 1'b1
        : en_q;

    // Prescale changes only inside the window
    assign ps_d = apply ? wd_ps : ps_q;

    // Oscillator rising edge gives one tick per period
    wire tick = osc_s && !osc_prev_q;

    // Timeout limit doubles with each prescale step
    wire [WDTU_CNT_W-1:0] base_w = WDTU_CNT_W'(BASE_TICKS);
    wire [WDTU_CNT_W-1:0] limit = base_w << ps_q;
    wire [WDTU_CNT_W-1:0] last = limit - 1'b1;
    wire at_lim = cnt_q >= last;

    // Restart wins over an expiry in the same cycle
    wire timeout = en_eff && tick && at_lim
        && !restart_req;
    wire cnt_clr = !en_eff || restart_req
        || timeout;

    // Counter next value
    assign cnt_d = cnt_clr ? '0
        : tick ? cnt_q + 1'b1
        : cnt_q;

    // Reset flag: set wins over a zero write
    assign flag_d = wdt_rst_q ? 1'b1
        : (wr_flag && !wdata[WDTU_FLAG_BIT]) ? 1'b0
        : flag_q;

    // Interrupt events; set wins over write-one-to-clear
    wire [WDTU_EV_N-1:0] ev = {refuse, timeout};
    wire [WDTU_EV_N-1:0] w1c = wr_sts ? wdata[WDTU_EV_N-1:0]
        : WDTU_EV_RST;
    assign sts_d = (sts_q & ~w1c) | ev;
    assign mask_d = wr_mask ? wdata[WDTU_EV_N-1:0] : mask_q;

    // Control readback, reserved bits zero
    wdtu_ctrl_s ctrl_rd;
    assign ctrl_rd.rsvd = 3'h0;
    assign ctrl_rd.ce = win_open;
    assign ctrl_rd.en = en_eff;
    assign ctrl_rd.ps = ps_q;

    // Read mux, unmapped reads zero
    wire [7:0] flag_rd = {7'h00, flag_q};
    wire [7:0] sts_rd = {6'h00, sts_q};
    wire [7:0] mask_rd = {6'h00, mask_q};
    wire [7:0] rd_mux = sel_ctrl ? ctrl_rd
        : sel_flag ? flag_rd
        : sel_sts ? sts_rd
        : sel_mask ? mask_rd
        : WDTU_DATA_ZERO;
    wire [7:0] rdata_d = rd ? rd_mux : WDTU_DATA_ZERO;

    // Control state and counter; chip reset clears counter
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            lock_q <= WDTU_LOCKED;
            win_q <= 2'h0;
            en_q <= 1'b0;
            ps_q <= WDTU_PS_RST;
            cnt_q <= '0;
            osc_prev_q <= 1'b0;
        end else if (clk_en) begin
            lock_q <= lock_d;
            win_q <= win_d;
            en_q <= en_d;
            ps_q <= ps_d;
            cnt_q <= cnt_d;
            osc_prev_q <= osc_s;
        end
    end

    // Reset pulse, interrupt and read data
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wdt_rst_q <= 1'b0;
            sts_q <= WDTU_EV_RST;
            mask_q <= WDTU_EV_RST;
            irq_q <= 1'b0;
            rdata_q <= WDTU_DATA_ZERO;
        end else if (clk_en) begin
            wdt_rst_q <= timeout;
            sts_q <= sts_d;
            mask_q <= mask_d;
            irq_q <= |(sts_d & mask_d);
            rdata_q <= rdata_d;
        end
    end

    // Reset flag survives chip reset, cleared by power-on
    always_ff @(posedge clk) begin
        if (!por_n) begin
            flag_q <= 1'b0;
        end else if (clk_en) begin
            flag_q <= flag_d;
        end
    end

    // Outputs
    assign rdata = rdata_q;
    assign irq = irq_q;
    assign wdt_rst = wdt_rst_q;

    // Checks

    sequence s_unlock;
        clk_en && unlock;
    endsequence

    sequence s_quiet;
        (clk_en && !unlock)[*4];
    endsequence

    property p_ce_open;
        @(posedge clk) disable iff (!rst_n || !clk_en)
        s_unlock |=> win_open[*4];
    endproperty
    a_ce_open: assert property (p_ce_open)
        else $error("change enable not held four cycles");

    property p_ce_close;
        @(posedge clk) disable iff (!rst_n || !clk_en)
        s_unlock ##1 s_quiet |=> !win_open;
    endproperty
    a_ce_close: assert property (p_ce_close)
        else $error("change enable did not self-clear");

    property p_dis_locked;
        @(posedge clk) disable iff (!rst_n || !clk_en)
        wr_ctrl && !win_open && !wd_en && en_q |=> en_q;
    endproperty
    a_dis_locked: assert property (p_dis_locked)
        else $error("enable cleared without unlock");

    property p_dis_window;
        @(posedge clk) disable iff (!rst_n || !clk_en)
        win_open && wr_ctrl && !wd_ce && !wd_en && !fuse_s
            |=> !en_eff ##1 cnt_q == '0;
    endproperty
    a_dis_window: assert property (p_dis_window)
        else $error("window disable not applied");

    property p_ps_locked;
        @(posedge clk) disable iff (!rst_n || !clk_en)
        !win_open |=> ps_q == $past(ps_q);
    endproperty
    a_ps_locked: assert property (p_ps_locked)
        else $error("prescale changed while locked");

    property p_rsvd;
        @(posedge clk) disable iff (!rst_n || !clk_en)
        rd && sel_ctrl |=> rdata[7:5] == 3'h0;
    endproperty
    a_rsvd: assert property (p_rsvd)
        else $error("reserved control bits not zero");

    property p_fuse_read;
        @(posedge clk) disable iff (!rst_n || !clk_en)
        rd && sel_ctrl && fuse_s |=> rdata[WDTU_EN_BIT];
    endproperty
    a_fuse_read: assert property (p_fuse_read)
        else $error("enable read zero with fuse programmed");

    property p_enable_free;
        @(posedge clk) disable iff (!rst_n || !clk_en)
        wr_ctrl && wd_en |=> en_q;
    endproperty
    a_enable_free: assert property (p_enable_free)
        else $error("enable write ignored");

    property p_pulse;
        @(posedge clk) disable iff (!rst_n || !clk_en)
        clk_en && timeout |=> wdt_rst ##1 !wdt_rst;
    endproperty
    a_pulse: assert property (p_pulse)
        else $error("reset pulse not one cycle");

    property p_flag;
        @(posedge clk) disable iff (!por_n || !clk_en)
        wdt_rst_q |=> flag_q;
    endproperty
    a_flag: assert property (p_flag)
        else $error("reset flag not set after timeout");

    property p_restart;
        @(posedge clk) disable iff (!rst_n || !clk_en)
        restart_req |=> cnt_q == '0 && !wdt_rst_q;
    endproperty
    a_restart: assert property (p_restart)
        else $error("restart did not clear counter");

    property p_expire;
        @(posedge clk) disable iff (!rst_n || !clk_en)
        en_eff && tick && at_lim && !restart_req
            |=> wdt_rst_q && cnt_q == '0;
    endproperty
    a_expire: assert property (p_expire)
        else $error("expiry did not reset the chip");

endmodule : wdtu_top

// file: sim/test_wdtu.sv
// Self-checking bench for the watchdog with timed unlock
`timescale 1ns/10ps
module test_wdtu
    import wdtu_pkg::*;
;
    localparam int BT = 4; // Short base count keeps runs brief
    logic clk;
    logic rst_n;
    logic por_n;
    logic osc_in;
    logic fuse_in;
    logic restart_req;
    logic wr;
    logic rd;
    logic [WDTU_ADDR_W-1:0] addr;
    logic [WDTU_DATA_W-1:0] wdata;
    logic [WDTU_DATA_W-1:0] rdata;
    logic irq;
    logic wdt_rst;
    logic rst_prev = 1'b0;
    int miscompares = 0;
    int samples_checked = 0;
    int pulses = 0;
    int wide = 0;
    int cycles = 0;
    int p;

    wdtu_top #(.BASE_TICKS(BT)) uut (
        .clk(clk), .rst_n(rst_n), .por_n(por_n), .clk_en(1'b1),
        .osc_in(osc_in), .fuse_in(fuse_in), .restart_req(restart_req),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .irq(irq), .wdt_rst(wdt_rst)
    );

    // Free-running system clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Counts reset pulses, over-long pulses and a hang limit
    always @(posedge clk) begin
        rst_prev <= wdt_rst;
        cycles <= cycles + 1;
        if (wdt_rst === 1'b1) begin
            pulses <= pulses + 1;
        end
        if (wdt_rst === 1'b1 && rst_prev === 1'b1) begin
            wide <= wide + 1;
        end
        if (cycles == 60000) begin
            miscompares++;
            test_done();
        end
    end

    task automatic test_done;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : test_done

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // Quiet bus for n cycles
    task automatic idle(input int n);
        wr <= 1'b0;
        rd <= 1'b0;
        repeat (n) @(posedge clk);
    endtask : idle

    task automatic wreg(input logic [2:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        rd <= 1'b0;
        @(posedge clk);
    endtask : wreg

    // Read strobe one cycle, data sampled in the cycle after it
    task automatic rchk(input logic [2:0] a, input logic [7:0] exp);
        addr <= a;
        rd <= 1'b1;
        wr <= 1'b0;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, exp);
        @(posedge clk);
    endtask : rchk

    // Oscillator periods of 20 system cycles
    task automatic tick(input int n);
        repeat (n) begin
            osc_in <= 1'b1;
            idle(10);
            osc_in <= 1'b0;
            idle(10);
        end
    endtask : tick

    task automatic restart;
        restart_req <= 1'b1;
        idle(1);
        restart_req <= 1'b0;
    endtask : restart

    // No pulse after n-1 ticks, exactly one after the n-th
    task automatic expire(input int n);
        p = pulses;
        tick(n - 1);
        idle(4);
        chk(8'(pulses - p), 8'h00);
        tick(1);
        idle(4);
        chk(8'(pulses - p), 8'h01);
    endtask : expire

    task automatic do_reset(input logic f);
        fuse_in <= f;
        rst_n <= 1'b0;
        por_n <= 1'b0;
        idle(4);
        rst_n <= 1'b1;
        por_n <= 1'b1;
        idle(3);
    endtask : do_reset

    // Main sequence
    initial begin
        {rst_n, por_n, osc_in, fuse_in, restart_req, wr, rd} = '0;
        addr = '0;
        wdata = '0;
        @(posedge clk);
        do_reset(1'b0);
        rchk(WDTU_OFS_CTRL, 8'h00);
        rchk(WDTU_OFS_FLAG, 8'h00);
        rchk(WDTU_OFS_STS, 8'h00);
        rchk(WDTU_OFS_MASK, 8'h00);
        wreg(3'h5, 8'hff);
        rchk(3'h5, 8'h00);
        $display("test reset values done");
        wreg(WDTU_OFS_CTRL, 8'he8);
        rchk(WDTU_OFS_CTRL, 8'h08);
        wreg(WDTU_OFS_MASK, 8'h03);
        wreg(WDTU_OFS_CTRL, 8'h02);
        rchk(WDTU_OFS_CTRL, 8'h08);
        chk({7'h0, irq}, 8'h01);
        rchk(WDTU_OFS_STS, 8'h02);
        wreg(WDTU_OFS_STS, 8'h02);
        idle(1);
        chk({7'h0, irq}, 8'h00);
        $display("test locked writes done");
        wreg(WDTU_OFS_CTRL, 8'h18);
        rchk(WDTU_OFS_CTRL, 8'h18);
        idle(3);
        rchk(WDTU_OFS_CTRL, 8'h08);
        wreg(WDTU_OFS_CTRL, 8'h18);
        idle(2);
        wreg(WDTU_OFS_CTRL, 8'h09);
        idle(5);
        rchk(WDTU_OFS_CTRL, 8'h09);
        wreg(WDTU_OFS_CTRL, 8'h18);
        idle(5);
        wreg(WDTU_OFS_CTRL, 8'h00);
        rchk(WDTU_OFS_CTRL, 8'h09);
        wreg(WDTU_OFS_STS, 8'h02);
        $display("test unlock window done");
        // Every prescale code, restarted then run to expiry
        for (int i = 0; i < 8; i++) begin
            wreg(WDTU_OFS_CTRL, 8'h18);
            wreg(WDTU_OFS_CTRL, 8'h08 | 8'(i));
            restart();
            expire(BT << i);
        end
        chk(8'(wide), 8'h00);
        rchk(WDTU_OFS_FLAG, 8'h01);
        rchk(WDTU_OFS_STS, 8'h01);
        chk({7'h0, irq}, 8'h01);
        wreg(WDTU_OFS_STS, 8'h01);
        idle(1);
        chk({7'h0, irq}, 8'h00);
        wreg(WDTU_OFS_FLAG, 8'h01);
        rchk(WDTU_OFS_FLAG, 8'h01);
        wreg(WDTU_OFS_FLAG, 8'h00);
        rchk(WDTU_OFS_FLAG, 8'h00);
        $display("test timeouts done");
        wreg(WDTU_OFS_CTRL, 8'h18);
        wreg(WDTU_OFS_CTRL, 8'h08);
        restart();
        tick(3);
        wreg(WDTU_OFS_CTRL, 8'h18);
        wreg(WDTU_OFS_CTRL, 8'h00);
        rchk(WDTU_OFS_CTRL, 8'h10);
        p = pulses;
        tick(6);
        chk(8'(pulses - p), 8'h00);
        wreg(WDTU_OFS_CTRL, 8'h08);
        expire(BT);
        $display("test disable done");
        do_reset(1'b1);
        rchk(WDTU_OFS_CTRL, 8'h08);
        wreg(WDTU_OFS_CTRL, 8'h18);
        wreg(WDTU_OFS_CTRL, 8'h00);
        rchk(WDTU_OFS_CTRL, 8'h18);
        idle(3);
        wreg(WDTU_OFS_CTRL, 8'h01);
        rchk(WDTU_OFS_CTRL, 8'h08);
        wreg(WDTU_OFS_CTRL, 8'h18);
        wreg(WDTU_OFS_CTRL, 8'h01);
        rchk(WDTU_OFS_CTRL, 8'h19);
        restart();
        expire(BT << 1);
        $display("test always on done");
        test_done();
    end

endmodule : test_wdtu
